// File: src/arsf_chain.v
/*
 * rate-sync sample timing and accelerometer composite filter chain.
 * assumes raw xyz samples on ACC_DATA, config as static ports, ref on a pin.
 */
// Function
// - in rate-sync mode, once locked, sample timing follows selected reference edges
// - both sensors in rate-sync use gyro rate code for accel too
// - lock reached after 3 reference periods
// - samples-per-ref field 4..255, giving 8..510 samples per period
// - polarity 0 syncs on falling edges, 1 on rising edges
// - first lowpass cutoff rate/2, or 2300/912/431 Hz in low-power modes
// - lowpass path, second lowpass optional, bandwidth from composite field
// - highpass path uses slope when field is 000, else ref-subtract when enabled, else highpass
// - slope equals current minus previous sample, halved, per axis
// - ref-subtract stores a sample and subtracts it from later outputs
// - fast-settle seeds selected filter from first sample after power-up
// - orientation select feeds second lowpass output to orientation
// - power mode change takes effect after current sample period
// - accel rate code 0000 means powered down
`timescale 1ns/1ps
`include "arsf_defines.vh"
module arsf_chain (
    input  wire        CORE_CLK,
    input  wire        SYS_RST,
    input  wire        SYNC_REF_INPUT_PIN,
    input  wire        REF_EDGE_POLARITY_BIT,
    input  wire [7:0]  SAMPLES_PER_REF_FIELD,
    input  wire [3:0]  ACCEL_RATE_CODE,
    input  wire [2:0]  ACCEL_OP_MODE,
    input  wire [3:0]  GYRO_RATE_CODE,
    input  wire [2:0]  GYRO_OP_MODE,
    input  wire [2:0]  COMPOSITE_BW_FIELD,
    input  wire        SECOND_LOWPASS_ENABLE,
    input  wire        HIGHPASS_PATH_SELECT,
    input  wire        REF_SUBTRACT_ENABLE,
    input  wire        FAST_SETTLE_ENABLE,
    input  wire        ORIENT_LOWPASS_SELECT,
    input  wire [47:0] ACC_DATA,
    output reg         SAMPLE_STROBE,
    output reg  [15:0] LP1_CUTOFF_HZ,
    output reg         LP1_HALF_RATE,
    output reg         ACC_POWERED_DOWN,
    output reg  [3:0]  EFFECTIVE_RATE_CODE,
    output reg         LOCKED,
    output reg         UNSETTLED,
    output reg  [47:0] ORIENT_DATA,
    output reg         OUT_VALID,
    input  wire        OUT_READY,
    output reg  [47:0] OUT_DATA,
    output reg         OUT_OVERFLOW
);
    // ----------------------------------------
    // reference pin synchroniser and edge pick
    // ----------------------------------------
    reg ref_s1_ff;
    reg ref_s2_ff;
    reg ref_s3_ff;
    always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ref_s1_ff <= 1'b0;
            ref_s2_ff <= 1'b0;
            ref_s3_ff <= 1'b0;
        end else begin
            ref_s1_ff <= SYNC_REF_INPUT_PIN;
            ref_s2_ff <= ref_s1_ff;
            ref_s3_ff <= ref_s2_ff;
        end
    end
    wire ref_rise = ref_s2_ff && !ref_s3_ff;
    wire ref_fall = !ref_s2_ff && ref_s3_ff;
    wire ref_edge = REF_EDGE_POLARITY_BIT ? ref_rise : ref_fall;

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    wire acc_pd  = (ACCEL_RATE_CODE == `ARSF_RATE_PD);
    wire gyr_pd  = (GYRO_RATE_CODE == `ARSF_RATE_PD);
    wire acc_trg = !acc_pd && (ACCEL_OP_MODE == `ARSF_MODE_TRIG);
    wire gyr_trg = !gyr_pd && (GYRO_OP_MODE == `ARSF_MODE_TRIG);
    wire trig    = acc_trg || gyr_trg;
    wire [3:0] eff_rate = (acc_trg && gyr_trg) ? GYRO_RATE_CODE : ACCEL_RATE_CODE;

    // ----------------------------------------
    // sample period generator
    // ----------------------------------------
    reg [23:0] per_cnt_ff;
    reg [23:0] meas_cnt_ff;
    reg [23:0] period_ff;
    reg [1:0]  edges_ff;
    reg        seen_ff;
    reg [2:0]  mode_ff;
    reg        pd_ff;
    reg [23:0] nxt_period;
    wire [8:0] n_samp   = {SAMPLES_PER_REF_FIELD, 1'b0};
    wire [23:0] nom_per = `ARSF_NOM_PERIOD >> eff_rate[1:0];
    wire locked_now     = (edges_ff == `ARSF_LOCK_PERIODS);
    wire per_done       = (per_cnt_ff == 24'h000000);
    wire strobe         = !pd_ff && (trig && locked_now ? (per_done || ref_edge) : per_done);

    always @* begin
        nxt_period = meas_cnt_ff / {15'h0000, n_samp};
        if (nxt_period == 24'h000000) begin
            nxt_period = 24'h000001;
        end
    end

    always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            per_cnt_ff  <= 24'h000000;
            meas_cnt_ff <= 24'h000000;
            period_ff   <= `ARSF_NOM_PERIOD;
            edges_ff    <= 2'h0;
            seen_ff     <= 1'b0;
            mode_ff     <= `ARSF_MODE_HP;
            pd_ff       <= 1'b1;
        end else begin
            if (!trig || acc_pd) begin
                edges_ff <= 2'h0;
                seen_ff  <= 1'b0;
            end else if (ref_edge) begin
                seen_ff     <= 1'b1;
                meas_cnt_ff <= 24'h000001;
                if (seen_ff) begin
                    period_ff <= nxt_period;
                end
                if (seen_ff && edges_ff != `ARSF_LOCK_PERIODS) begin
                    edges_ff <= edges_ff + 2'h1;
                end
            end else begin
                meas_cnt_ff <= meas_cnt_ff + 24'h000001;
            end
            if (ref_edge && trig && locked_now) begin
                per_cnt_ff <= period_ff - 24'h000001;
            end else if (per_done) begin
                // powered down: no period to finish, check the rate code again on the next clock
                per_cnt_ff <= acc_pd ? 24'h000000 :
                              (trig && locked_now) ? period_ff - 24'h000001 : nom_per;
                mode_ff    <= ACCEL_OP_MODE;
                pd_ff      <= acc_pd;
            end else begin
                per_cnt_ff <= per_cnt_ff - 24'h000001;
            end
        end
    end

    // ----------------------------------------
    // composite filter chain, per axis
    // ----------------------------------------
    reg        hp_ref_ff;
    reg        seed_ff;
    reg        was_pd_ff;
    wire       use_ref = HIGHPASS_PATH_SELECT && REF_SUBTRACT_ENABLE &&
                         (COMPOSITE_BW_FIELD != `ARSF_BW_SLOPE);
    wire       seed    = seed_ff || !hp_ref_ff && use_ref;
    wire [47:0] filt;
    wire [47:0] lp2_out;
    wire [47:0] hp_out;
    // lowpass shift one past the field, widened so code 7 does not wrap
    wire [3:0]  lp_shift = {1'b0, COMPOSITE_BW_FIELD} + 4'h1;
    reg  [47:0] prev_ff;
    reg  [47:0] lp2_ff;
    reg  [47:0] hp_ff;
    reg  [47:0] ref_ff;

    genvar ax;
    generate
        for (ax = 0; ax < 3; ax = ax + 1) begin : g_axis
            wire signed [15:0] x    = ACC_DATA[16*ax+15:16*ax];
            wire signed [15:0] xp   = prev_ff[16*ax+15:16*ax];
            wire signed [15:0] lp   = lp2_ff[16*ax+15:16*ax];
            wire signed [15:0] hl   = hp_ff[16*ax+15:16*ax];
            wire signed [15:0] rf   = ref_ff[16*ax+15:16*ax];
            wire signed [16:0] dif  = {x[15], x} - {xp[15], xp};
            wire signed [15:0] slope = dif[16:1];
            wire signed [16:0] ld   = {x[15], x} - {lp[15], lp};
            wire signed [16:0] lsh  = ld >>> lp_shift;
            wire signed [15:0] lnew = seed ? x : lp + lsh[15:0];
            wire signed [16:0] hd   = {x[15], x} - {hl[15], hl};
            wire signed [16:0] hsh  = hd >>> COMPOSITE_BW_FIELD;
            wire signed [15:0] hnew = seed ? x : hl + hsh[15:0];
            wire signed [16:0] rsub = {x[15], x} - {rf[15], rf};
            reg  signed [15:0] sel;
            always @* begin
                if (!HIGHPASS_PATH_SELECT) begin
                    sel = SECOND_LOWPASS_ENABLE ? lnew : x;
                end else if (COMPOSITE_BW_FIELD == `ARSF_BW_SLOPE) begin
                    sel = slope;
                end else if (REF_SUBTRACT_ENABLE) begin
                    sel = rsub[15:0];
                end else begin
                    sel = x - hnew;
                end
            end
            assign filt[16*ax+15:16*ax]    = sel;
            assign lp2_out[16*ax+15:16*ax] = lnew;
            assign hp_out[16*ax+15:16*ax]  = hnew;
        end
    endgenerate

    // ----------------------------------------
    // output register handshake
    // ----------------------------------------
    wire        out_take = !OUT_VALID || OUT_READY;   // refill when empty or drained

    // ----------------------------------------
    // fifo on the output path
    // ----------------------------------------
    wire        f_in_ready;
    wire        f_out_valid;
    wire [47:0] f_out_data;
    arsf_fifo #(
        .WIDTH (`ARSF_AXW),
        .DEPTH (`ARSF_FIFO_DEPTH),
        .AW    (`ARSF_FIFO_AW)
    ) u_fifo (
        .clk       (CORE_CLK),
        .rst       (SYS_RST),
        .in_valid  (strobe),
        .in_ready  (f_in_ready),
        .in_data   (filt),
        .out_valid (f_out_valid),
        .out_ready (out_take),
        .out_data  (f_out_data)
    );

    // ----------------------------------------
    // filter state and registered outputs
    // ----------------------------------------
    always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            prev_ff             <= 48'h000000000000;
            lp2_ff              <= 48'h000000000000;
            hp_ff               <= 48'h000000000000;
            ref_ff              <= 48'h000000000000;
            hp_ref_ff           <= 1'b0;
            seed_ff             <= 1'b1;
            was_pd_ff           <= 1'b1;
            SAMPLE_STROBE       <= 1'b0;
            LP1_CUTOFF_HZ       <= 16'h0000;
            LP1_HALF_RATE       <= 1'b1;
            ACC_POWERED_DOWN    <= 1'b1;
            EFFECTIVE_RATE_CODE <= 4'h0;
            LOCKED              <= 1'b0;
            UNSETTLED           <= 1'b1;
            ORIENT_DATA         <= 48'h000000000000;
            OUT_VALID           <= 1'b0;
            OUT_DATA            <= 48'h000000000000;
            OUT_OVERFLOW        <= 1'b0;
        end else begin
            was_pd_ff <= pd_ff;
            if (was_pd_ff && !pd_ff) begin
                seed_ff <= FAST_SETTLE_ENABLE;
            end else if (strobe) begin
                seed_ff <= 1'b0;
            end
            if (strobe) begin
                prev_ff   <= ACC_DATA;
                lp2_ff    <= lp2_out;
                hp_ff     <= hp_out;
                hp_ref_ff <= use_ref;
                if (use_ref && !hp_ref_ff) begin
                    ref_ff <= ACC_DATA;
                end
                if (ORIENT_LOWPASS_SELECT) begin
                    ORIENT_DATA <= lp2_out;
                end else begin
                    ORIENT_DATA <= ACC_DATA;
                end
            end
            if (!use_ref) begin
                hp_ref_ff <= 1'b0;
            end
            SAMPLE_STROBE <= strobe;
            case (mode_ff)
                `ARSF_MODE_LP1: LP1_CUTOFF_HZ <= `ARSF_LP1_CUT_HZ;
                `ARSF_MODE_LP2: LP1_CUTOFF_HZ <= `ARSF_LP2_CUT_HZ;
                `ARSF_MODE_LP3: LP1_CUTOFF_HZ <= `ARSF_LP3_CUT_HZ;
                default:        LP1_CUTOFF_HZ <= 16'h0000;
            endcase
            LP1_HALF_RATE       <= (mode_ff < `ARSF_MODE_LP1);
            ACC_POWERED_DOWN    <= pd_ff;
            EFFECTIVE_RATE_CODE <= eff_rate;
            LOCKED              <= trig && locked_now;
            UNSETTLED           <= trig && !locked_now;
            if (out_take) begin
                OUT_VALID <= f_out_valid;
                OUT_DATA  <= f_out_data;
            end
            OUT_OVERFLOW        <= strobe && !f_in_ready;
        end
    end
endmodule

// File: src/arsf_defines.vh
/*
 * constants for the rate-sync filter chain: codes, field widths, timing counts.
 * assumes inclusion by the design files only.
 */
`ifndef ARSF_DEFINES_VH
`define ARSF_DEFINES_VH

`define ARSF_DW            16
`define ARSF_AXW           48
`define ARSF_FIFO_DEPTH    32
`define ARSF_FIFO_AW       5
`define ARSF_RATE_PD       4'h0
`define ARSF_MODE_HP       3'h0
`define ARSF_MODE_HA       3'h1
`define ARSF_MODE_TRIG     3'h2
`define ARSF_MODE_NORM     3'h3
`define ARSF_MODE_LP1      3'h4
`define ARSF_MODE_LP2      3'h5
`define ARSF_MODE_LP3      3'h6
`define ARSF_BW_SLOPE      3'h0
`define ARSF_LOCK_PERIODS  2'h3
`define ARSF_NOM_PERIOD    24'h00F424
`define ARSF_CLK_MHZ       100
`define ARSF_LP1_CUT_HZ    16'h08FC
`define ARSF_LP2_CUT_HZ    16'h0390
`define ARSF_LP3_CUT_HZ    16'h01AF
`define ARSF_PERW          24

`endif

// File: src/arsf_fifo.v
/*
 * synchronous fifo with valid/ready on both sides, registered read data.
 * assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module arsf_fifo #(
    parameter WIDTH = 48,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output reg              out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    // ----------------------------------------
    // storage and pointers
    // ----------------------------------------
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_ff;
    reg [AW:0]      rd_ptr_ff;
    wire            full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    wire            empty = (wr_ptr_ff == rd_ptr_ff);
    wire            push  = in_valid && !full;
    wire            pop   = !empty && (!out_valid || out_ready);

    assign in_ready = !full;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
                out_data  <= mem[rd_ptr_ff[AW-1:0]];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

// File: dv/arsf_chain_properties.sv
/*
 * port-level assertions for arsf_chain.
 * assumes it is bound onto every arsf_chain instance.
 */
`timescale 1ns/1ps
module arsf_chain_properties (
    input wire        CORE_CLK,
    input wire        SYS_RST,
    input wire [3:0]  ACCEL_RATE_CODE,
    input wire [2:0]  ACCEL_OP_MODE,
    input wire [3:0]  GYRO_RATE_CODE,
    input wire [2:0]  GYRO_OP_MODE,
    input wire        SAMPLE_STROBE,
    input wire [15:0] LP1_CUTOFF_HZ,
    input wire        LP1_HALF_RATE,
    input wire        ACC_POWERED_DOWN,
    input wire [3:0]  EFFECTIVE_RATE_CODE,
    input wire        LOCKED,
    input wire        UNSETTLED,
    input wire        OUT_VALID,
    input wire        OUT_READY,
    input wire [47:0] OUT_DATA,
    input wire        OUT_OVERFLOW
);
// ----------------------------------------
// sequences and assertions
// ----------------------------------------
default clocking cb @(posedge CORE_CLK); endclocking
default disable iff (SYS_RST);
sequence s_stall;
    OUT_VALID && !OUT_READY ##1 !OUT_READY;
endsequence
sequence s_sync_run;
    LOCKED && ACCEL_OP_MODE == 3'h2 && GYRO_OP_MODE == 3'h2 && ACCEL_RATE_CODE != 4'h0 && GYRO_RATE_CODE != 4'h0;
endsequence
a_strobe_one_cycle: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE)
    else $error("sample strobe wider than one cycle");
a_pd_exit_rate: assert property ($fell(ACC_POWERED_DOWN) |-> ACCEL_RATE_CODE != 4'h0)
    else $error("power-down left with rate code zero");
a_lock_settled: assert property (LOCKED |-> !UNSETTLED)
    else $error("unsettled flag while locked");
a_lp1_cut_codes: assert property (LP1_CUTOFF_HZ inside {16'h0000, 16'h08FC, 16'h0390, 16'h01AF})
    else $error("first lowpass cutoff not a legal value");
a_half_rate_excl: assert property (LP1_HALF_RATE |-> LP1_CUTOFF_HZ == 16'h0000)
    else $error("half-rate cutoff with fixed cutoff");
a_out_hold: assert property (s_stall |=> OUT_VALID && $stable(OUT_DATA))
    else $error("output changed while stalled");
a_ovf_pulse: assert property (OUT_OVERFLOW |=> !OUT_OVERFLOW)
    else $error("overflow flag wider than one cycle");
a_gyro_rate_wins: assert property (s_sync_run ##1 SAMPLE_STROBE |-> EFFECTIVE_RATE_CODE == GYRO_RATE_CODE)
    else $error("accel rate not taken from gyro");
endmodule
bind arsf_chain arsf_chain_properties arsf_chain_properties_inst (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .ACCEL_RATE_CODE(ACCEL_RATE_CODE), .ACCEL_OP_MODE(ACCEL_OP_MODE),
    .GYRO_RATE_CODE(GYRO_RATE_CODE), .GYRO_OP_MODE(GYRO_OP_MODE), .SAMPLE_STROBE(SAMPLE_STROBE),
    .LP1_CUTOFF_HZ(LP1_CUTOFF_HZ), .LP1_HALF_RATE(LP1_HALF_RATE), .ACC_POWERED_DOWN(ACC_POWERED_DOWN),
    .EFFECTIVE_RATE_CODE(EFFECTIVE_RATE_CODE), .LOCKED(LOCKED), .UNSETTLED(UNSETTLED), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .OUT_OVERFLOW(OUT_OVERFLOW));

// File: dv/arsf_ref_src.sv
/*
 * external timing source: periodic reference pulse.
 * assumes period and pulse length in core clock cycles.
 */
`timescale 1ns/1ps
module arsf_ref_src (
    input wire        clk,
    input wire        en,
    input wire        pol,
    input wire [15:0] period,
    input wire [15:0] high_len,
    output reg        ref_out
);
// ----------------------------------------
// pulse generation
// ----------------------------------------
reg [15:0] cnt_ff = 16'h0000;
initial ref_out = 1'b0;
always @(posedge clk) begin
    if (!en) begin
        cnt_ff  <= 16'h0000;
        ref_out <= !pol;                                                 // idle at inactive level
    end else begin
        cnt_ff  <= (cnt_ff == period - 16'h0001) ? 16'h0000 : cnt_ff + 16'h0001;
        ref_out <= (cnt_ff < high_len) ? pol : !pol;
    end
end
endmodule

// File: dv/tb_top.sv
/*
 * self-checking bench for arsf_chain with reference source.
 * assumes fifo output lands in order, one note per sample strobe.
 */
`timescale 1ns/1ps
module tb_top;
reg         core_clk = 1'b0, sys_rst = 1'b1, pol = 1'b1, ref_en = 1'b0, ref_q = 1'b0;
reg  [7:0]  spr = 8'h04;
reg  [3:0]  arate = 4'h0, grate = 4'h0;
reg  [2:0]  amode = 3'h2, gmode = 3'h2, bw = 3'h0;
reg         lp2 = 1'b0, hps = 1'b0, refs = 1'b0, fast = 1'b0, olp = 1'b0, rdy = 1'b1;
reg  [47:0] acc = 48'h0, prv = 48'h0, refv = 48'h0;
reg  [63:0] rnd;
reg  [48:0] note;
reg  [48:0] expq [$];
wire        ref_pin, stb, half, pd, locked, unset, ovalid, ovf;
wire [15:0] cut;
wire [3:0]  eff;
wire [47:0] orient, odata;
integer     fail_count = 0, checks_done = 0, mode = 3, skip = 0, ovf_n = 0, p, m, n;
integer     nedge = 0, nstb = 0, lastn = 0, since = 0, gap = 0, gmin = 9999, gmax = 0, dly = 0, seen = 0;
always #5 core_clk = ~core_clk;
arsf_ref_src arsf_ref_src_inst (.clk(core_clk), .en(ref_en), .pol(pol), .period(16'h04B0), .high_len(16'h0208),
    .ref_out(ref_pin));
arsf_chain arsf_chain_inst (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .SYNC_REF_INPUT_PIN(ref_pin), .REF_EDGE_POLARITY_BIT(pol),
    .SAMPLES_PER_REF_FIELD(spr), .ACCEL_RATE_CODE(arate), .ACCEL_OP_MODE(amode), .GYRO_RATE_CODE(grate),
    .GYRO_OP_MODE(gmode), .COMPOSITE_BW_FIELD(bw), .SECOND_LOWPASS_ENABLE(lp2), .HIGHPASS_PATH_SELECT(hps),
    .REF_SUBTRACT_ENABLE(refs), .FAST_SETTLE_ENABLE(fast), .ORIENT_LOWPASS_SELECT(olp), .ACC_DATA(acc),
    .SAMPLE_STROBE(stb), .LP1_CUTOFF_HZ(cut), .LP1_HALF_RATE(half), .ACC_POWERED_DOWN(pd),
    .EFFECTIVE_RATE_CODE(eff), .LOCKED(locked), .UNSETTLED(unset), .ORIENT_DATA(orient), .OUT_VALID(ovalid),
    .OUT_READY(rdy), .OUT_DATA(odata), .OUT_OVERFLOW(ovf));
// ----------------------------------------
// shared tasks
// ----------------------------------------
function [47:0] axdiff(input [47:0] c, input [47:0] r, input halve);
    integer i;
    reg [15:0] d;
    begin
        for (i = 0; i < 3; i = i + 1) begin
            d = c[i*16 +: 16] - r[i*16 +: 16];
            axdiff[i*16 +: 16] = halve ? {d[15], d[15:1]} : d;
        end
    end
endfunction
task check(input [47:0] got, input [47:0] want, input [8*12:1] what);
    begin
        checks_done = checks_done + 1;
        if (got !== want) begin
            fail_count = fail_count + 1;
            $display("BAD %0s expected %h seen %h", what, want, got);
        end
    end
endtask
task wrap_up;
    begin
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    end
endtask
task wait_sig(input sel);
    begin
        n = 0;
        while ((sel ? locked : stb) !== 1'b1 && n < 20000) begin
            @(negedge core_clk);
            n = n + 1;
        end
        if (n >= 20000) begin
            fail_count = fail_count + 1;
            $display("BAD wait expected done seen timeout");
            wrap_up;
        end
    end
endtask
// ----------------------------------------
// driver notes, output monitor, strobe timing
// ----------------------------------------
always @(negedge core_clk) begin
    if (stb === 1'b1) begin
        if (skip > 0) skip = skip - 1;
        if (skip > 0 || mode == 3) expq.push_back(49'h0);
        else if (mode == 0) expq.push_back({1'b1, acc});
        else if (mode == 1) expq.push_back({1'b1, axdiff(acc, prv, 1'b1)});
        else expq.push_back({1'b1, axdiff(acc, refv, 1'b0)});
        if (olp === 1'b0) check(orient, acc, "orient");
        prv = acc;
        rnd = {$urandom, $urandom};
        if (mode != 2 || skip == 0) acc = rnd[47:0] & 48'h0FFE0FFE0FFE;
    end
end
always @(posedge core_clk) begin
    if (ovf === 1'b1) begin
        ovf_n = ovf_n + 1;
        void'(expq.pop_back());
    end
    if (ovalid === 1'b1 && rdy === 1'b1) begin
        if (expq.size() == 0) check(1'b1, 1'b0, "spare output");
        else begin
            note = expq.pop_front();
            if (note[48]) check(odata, note[47:0], "out data");
        end
    end
    ref_q <= ref_pin;
    since = since + 1;
    gap = gap + 1;
    if (ref_pin === pol && ref_q === !pol) begin
        nedge = nedge + 1;
        lastn = nstb;
        nstb = 0;
        since = 0;
        seen = 0;
    end
    if (stb === 1'b1) begin
        nstb = nstb + 1;
        if (gap < gmin) gmin = gap;
        if (gap > gmax) gmax = gap;
        if (seen == 0) dly = since;
        seen = 1;
        gap = 0;
    end
end
// ----------------------------------------
// main sequence
// ----------------------------------------
initial begin
    rnd = $urandom(32'h3B145BA2);
    for (p = 0; p < 2; p = p + 1) begin
        sys_rst = 1'b1;
        ref_en = 1'b0;
        arate = 4'h0;
        grate = 4'h0;
        mode = 3;
        expq.delete();
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        check(pd, 1'b1, "pd at reset");
        pol = (p == 0);
        nedge = 0;
        ref_en = 1'b1;
        arate = 4'h7;
        grate = 4'h6;
        @(negedge core_clk);
        check(unset, 1'b1, "pre lock");
        wait_sig(1'b1);
        check(nedge, 4, "lock edges");
        check(unset, 1'b0, "post lock");
        mode = 0;
        skip = 2;
        repeat (1200) @(negedge core_clk);
        check(eff, 4'h6, "eff rate");
        gmin = 9999;
        gmax = 0;
        repeat (1200) @(negedge core_clk);
        check(lastn, 8, "per period");
        check(gmin >= 148 && gmax <= 152, 1'b1, "spacing");
        check(dly >= 1 && dly <= 8, 1'b1, "edge align");
        hps = 1'b1;
        skip = 2;
        mode = 1;
        repeat (1200) @(negedge core_clk);
        refs = 1'b1;
        bw = 3'h1;
        refv = acc;
        skip = 3;
        mode = 2;
        repeat (1200) @(negedge core_clk);
        refs = 1'b0;
        hps = 1'b0;
        bw = 3'h0;
        skip = 2;
        mode = 0;
        repeat (600) @(negedge core_clk);
        if (p == 0) begin
            mode = 3;
            rdy = 1'b0;
            repeat (5400) @(negedge core_clk);
            check(ovf_n > 0, 1'b1, "fifo full");
            rdy = 1'b1;
            mode = 0;
            repeat (600) @(negedge core_clk);
        end
    end
    mode = 3;
    arate = 4'h0;
    grate = 4'h0;
    ref_en = 1'b0;
    repeat (400) @(negedge core_clk);
    check(pd, 1'b1, "pd on zero");
    amode = 3'h3;
    @(negedge core_clk);
    arate = 4'hB;
    for (m = 3; m < 7; m = m + 1) begin
        amode = m[2:0];
        @(negedge core_clk);
        wait_sig(1'b0);
        repeat (2) @(negedge core_clk);
        check(cut, (m == 4) ? 16'h08FC : (m == 5) ? 16'h0390 : (m == 6) ? 16'h01AF : 16'h0000, "lp1 cut");
        check(half, m == 3, "lp1 half");
    end
    wrap_up;
end
endmodule
